// [verilog/baud_map.svh]
`ifndef BAUD_MAP_SVH
`define BAUD_MAP_SVH

// ************************************************************
// Register offsets (byte addresses, one word each)
// ************************************************************
`define REG_RATE_SEL 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_DIVISORS 8'h0C

// ************************************************************
// Field positions
// ************************************************************
`define RATE_SEL_RX_LSB 0
`define RATE_SEL_TX_LSB 4
`define CTRL_RX_STROBE_BIT 0
`define CTRL_TX_STROBE_BIT 1
`define CTRL_SRC_REGS_BIT 2
`define STATUS_RX_CODE_LSB 0
`define STATUS_TX_CODE_LSB 4
`define STATUS_RX_OUT_BIT 8
`define STATUS_TX_OUT_BIT 9
`define DIVISORS_RX_LSB 0
`define DIVISORS_TX_LSB 16

// ************************************************************
// Reset values
// ************************************************************
`define RATE_SEL_RESET 8'h00
`define CTRL_RESET 3'h0
`define CODE_RESET 4'h0

// ************************************************************
// Divisor table, indexed by the 4-bit selection code
// ************************************************************
`define DIV_CODE_0 13'h18C0
`define DIV_CODE_1 13'h1080
`define DIV_CODE_2 13'h0B40
`define DIV_CODE_3 13'h0933
`define DIV_CODE_4 13'h0840
`define DIV_CODE_5 13'h0420
`define DIV_CODE_6 13'h0210
`define DIV_CODE_7 13'h0108
`define DIV_CODE_8 13'h00B0
`define DIV_CODE_9 13'h009E
`define DIV_CODE_10 13'h0084
`define DIV_CODE_11 13'h0058
`define DIV_CODE_12 13'h0042
`define DIV_CODE_13 13'h002C
`define DIV_CODE_14 13'h0021
`define DIV_CODE_15 13'h0010

`endif

// [verilog/baud_pkg.sv]
package baud_pkg;

	// ************************************************************
	// Types
	// ************************************************************
	typedef logic [3:0] rate_code_t;
	typedef logic [12:0] divisor_t;

	typedef struct packed {
		rate_code_t code;
		logic strobe;
	} sel_req_t;

	typedef struct packed {
		rate_code_t code;
		divisor_t divisor;
		logic clk_out;
	} section_state_t;

	typedef enum {
		REG_SEL_RATE,
		REG_SEL_CTRL,
		REG_SEL_STATUS,
		REG_SEL_DIVISORS,
		REG_SEL_NONE
	} reg_sel_t;

endpackage

// [verilog/ref_tick_detect.sv]
`timescale 1ns/100ps
`include "baud_map.svh"

module ref_tick_detect import baud_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ref_clock_in,
	output logic ref_tick
);

	logic level_r;
	logic level_nxt;
	logic tick_r;
	logic tick_nxt;

	// One pulse per rising edge of the reference; the reference must stay
	// well below half of the system clock for no edge to be missed.
	always_comb begin
		level_nxt = ref_clock_in;
		tick_nxt = ref_clock_in & ~level_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			level_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign ref_tick = tick_r;

endmodule

// [verilog/divisor_rom.sv]
`timescale 1ns/100ps
`include "baud_map.svh"

module divisor_rom import baud_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input rate_code_t addr,
	output divisor_t data
);

	divisor_t data_r;
	divisor_t data_nxt;

	always_comb begin
		unique case (addr)
			4'h0: data_nxt = `DIV_CODE_0;
			4'h1: data_nxt = `DIV_CODE_1;
			4'h2: data_nxt = `DIV_CODE_2;
			4'h3: data_nxt = `DIV_CODE_3;
			4'h4: data_nxt = `DIV_CODE_4;
			4'h5: data_nxt = `DIV_CODE_5;
			4'h6: data_nxt = `DIV_CODE_6;
			4'h7: data_nxt = `DIV_CODE_7;
			4'h8: data_nxt = `DIV_CODE_8;
			4'h9: data_nxt = `DIV_CODE_9;
			4'hA: data_nxt = `DIV_CODE_10;
			4'hB: data_nxt = `DIV_CODE_11;
			4'hC: data_nxt = `DIV_CODE_12;
			4'hD: data_nxt = `DIV_CODE_13;
			4'hE: data_nxt = `DIV_CODE_14;
			4'hF: data_nxt = `DIV_CODE_15;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			data_r <= `DIV_CODE_0;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign data = data_r;

endmodule

// [verilog/dual_baud_rate_divider.sv]
`timescale 1ns/100ps
`include "baud_map.svh"


module dual_baud_rate_divider import baud_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ref_clock_in,
	input wire logic rx_sel_bit0,
	input wire logic rx_sel_bit1,
	input wire logic rx_sel_bit2,
	input wire logic rx_sel_bit3,
	input wire logic rx_select_strobe,
	input wire logic tx_sel_bit0,
	input wire logic tx_sel_bit1,
	input wire logic tx_sel_bit2,
	input wire logic tx_sel_bit3,
	input wire logic tx_select_strobe,
	output logic rx_rate_clock_out,
	output logic tx_rate_clock_out
);

	// ************************************************************
	// Address decode
	// ************************************************************
	function automatic reg_sel_t decode_reg(input logic [7:0] adr);
		reg_sel_t sel;
		unique case (adr)
			`REG_RATE_SEL: sel = REG_SEL_RATE;
			`REG_CTRL: sel = REG_SEL_CTRL;
			`REG_STATUS: sel = REG_SEL_STATUS;
			`REG_DIVISORS: sel = REG_SEL_DIVISORS;
			default: sel = REG_SEL_NONE;
		endcase
		return sel;
	endfunction

	// ************************************************************
	// Register bus state
	// ************************************************************
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [7:0] rate_sel_r;
	logic [7:0] rate_sel_nxt;
	logic [2:0] ctrl_r;
	logic [2:0] ctrl_nxt;

	logic ref_tick;
	sel_req_t req [2];
	section_state_t sec [2];
	reg_sel_t bus_sel;
	logic bus_req;

	assign bus_sel = decode_reg(wb_adr_i);
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;

	// Ack comes one cycle after the request and drops in the next, so a
	// master that holds its request sees a fresh acknowledge every second cycle.
	always_comb begin
		ack_nxt = bus_req;
		rate_sel_nxt = rate_sel_r;
		ctrl_nxt = ctrl_r;
		rdata_nxt = 32'h0000_0000;
		if (bus_req && wb_we_i && wb_sel_i[0]) begin
			if (bus_sel == REG_SEL_RATE) begin
				rate_sel_nxt = wb_dat_i[7:0];
			end
			if (bus_sel == REG_SEL_CTRL) begin
				ctrl_nxt = wb_dat_i[2:0];
			end
		end
		if (bus_req && !wb_we_i) begin
			unique case (bus_sel)
				REG_SEL_RATE: rdata_nxt[7:0] = rate_sel_r;
				REG_SEL_CTRL: rdata_nxt[2:0] = ctrl_r;
				REG_SEL_STATUS: begin
					rdata_nxt[`STATUS_RX_CODE_LSB +: 4] = sec[0].code;
					rdata_nxt[`STATUS_TX_CODE_LSB +: 4] = sec[1].code;
					rdata_nxt[`STATUS_RX_OUT_BIT] = sec[0].clk_out;
					rdata_nxt[`STATUS_TX_OUT_BIT] = sec[1].clk_out;
				end
				REG_SEL_DIVISORS: begin
					rdata_nxt[`DIVISORS_RX_LSB +: 13] = sec[0].divisor;
					rdata_nxt[`DIVISORS_TX_LSB +: 13] = sec[1].divisor;
				end
				REG_SEL_NONE: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rate_sel_r <= `RATE_SEL_RESET;
			ctrl_r <= `CTRL_RESET;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			rate_sel_r <= rate_sel_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ************************************************************
	// Selection sources
	// ************************************************************
	// Software may take over the select codes and strobes; by default the
	// controller pins drive them.
	always_comb begin
		if (ctrl_r[`CTRL_SRC_REGS_BIT]) begin
			req[0].code = rate_sel_r[`RATE_SEL_RX_LSB +: 4];
			req[0].strobe = ctrl_r[`CTRL_RX_STROBE_BIT];
			req[1].code = rate_sel_r[`RATE_SEL_TX_LSB +: 4];
			req[1].strobe = ctrl_r[`CTRL_TX_STROBE_BIT];
		end else begin
			req[0].code = {rx_sel_bit3, rx_sel_bit2, rx_sel_bit1, rx_sel_bit0};
			req[0].strobe = rx_select_strobe;
			req[1].code = {tx_sel_bit3, tx_sel_bit2, tx_sel_bit1, tx_sel_bit0};
			req[1].strobe = tx_select_strobe;
		end
	end

	// ************************************************************
	// Reference edge
	// ************************************************************
	ref_tick_detect ref_tick_detect_inst (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.ref_clock_in(ref_clock_in),
		.ref_tick(ref_tick)
	);

	// ************************************************************
	// Divider sections
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_section
			rate_code_t code_r;
			rate_code_t code_nxt;
			divisor_t div;
			divisor_t cnt_r;
			divisor_t cnt_nxt;
			divisor_t half;
			logic out_r;
			logic out_nxt;

			divisor_rom divisor_rom_inst (
				.clk_sys(clk_sys),
				.reset_n(reset_n),
				.addr(code_r),
				.data(div)
			);

			// Odd divisors spend the extra reference period high.
			assign half = (div + 13'h0001) >> 1;

			always_comb begin
				code_nxt = code_r;
				if (req[gi].strobe) begin
					code_nxt = req[gi].code;
				end
				cnt_nxt = cnt_r;
				if (ref_tick) begin
					// The compare uses >= so a shorter new divisor never
					// leaves the count stranded above its end.
					if (cnt_r >= div - 13'h0001) begin
						cnt_nxt = 13'h0000;
					end else begin
						cnt_nxt = cnt_r + 13'h0001;
					end
				end
				out_nxt = cnt_nxt < half;
			end

			always_ff @(posedge clk_sys) begin
				if (!reset_n) begin
					code_r <= `CODE_RESET;
					cnt_r <= 13'h0000;
					out_r <= 1'b0;
				end else begin
					code_r <= code_nxt;
					cnt_r <= cnt_nxt;
					out_r <= out_nxt;
				end
			end

			assign sec[gi].code = code_r;
			assign sec[gi].divisor = div;
			assign sec[gi].clk_out = out_r;
		end
	endgenerate

	assign rx_rate_clock_out = sec[0].clk_out;
	assign tx_rate_clock_out = sec[1].clk_out;

endmodule

// [verif/line_side.sv]
`timescale 1ns/100ps

// ********
// Line side
// ********
module line_side (
	output logic ref_clk,
	input wire logic rx_clk,
	input wire logic tx_clk,
	output int rx_per,
	output int tx_per
);
	int n = 0;
	int rx_at = 0;
	int tx_at = 0;
	// Free running, so its phase drifts against the system clock; the odd
	// start offset keeps every edge off the system clock's edges.
	initial begin
		ref_clk = 1'b0;
		#0.1;
		forever #98.6 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) n++;
	// Reference edges between rising edges of each rate clock.
	always @(posedge rx_clk) begin
		rx_per = n - rx_at;
		rx_at = n;
	end
	always @(posedge tx_clk) begin
		tx_per = n - tx_at;
		tx_at = n;
	end
endmodule

// [verif/baud_sva.sv]
`timescale 1ns/100ps

// ********
// Port checks
// ********
module baud_sva (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic rx_sel_bit0,
	input wire logic rx_sel_bit1,
	input wire logic rx_sel_bit2,
	input wire logic rx_sel_bit3,
	input wire logic rx_select_strobe,
	input wire logic tx_sel_bit0,
	input wire logic tx_sel_bit1,
	input wire logic tx_sel_bit2,
	input wire logic tx_sel_bit3,
	input wire logic tx_select_strobe,
	input wire logic rx_rate_clock_out,
	input wire logic tx_rate_clock_out
);
	logic rx_q, tx_q, rd_st, src;
	logic [3:0] rx_m, tx_m, rx_pin, tx_pin;
	logic [4:0] calm;
	logic busy;
	logic [13:0] rx_cnt, tx_cnt;
	assign rx_pin = {rx_sel_bit3, rx_sel_bit2, rx_sel_bit1, rx_sel_bit0};
	assign tx_pin = {tx_sel_bit3, tx_sel_bit2, tx_sel_bit1, tx_sel_bit0};
	// A new divisor may cut the phase in progress short, so phase widths are
	// only held to the minimum once the selection has been quiet for a while.
	assign busy = calm < 5'h18;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// The longest half period, 3168 reference cycles, stays below 16000 cycles.
	always_ff @(posedge clk_sys) begin
		rx_q <= rx_rate_clock_out;
		tx_q <= tx_rate_clock_out;
		rx_cnt <= (!reset_n || rx_q != rx_rate_clock_out) ? 14'h0 : rx_cnt + 14'h1;
		tx_cnt <= (!reset_n || tx_q != tx_rate_clock_out) ? 14'h0 : tx_cnt + 14'h1;
		rd_st <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
		if (!reset_n) begin
			src <= 1'b0;
			rx_m <= 4'h0;
			tx_m <= 4'h0;
			calm <= 5'h00;
		end else begin
			if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h04)
				src <= wb_dat_i[2];
			if (rx_select_strobe && !src)
				rx_m <= rx_pin;
			if (tx_select_strobe && !src)
				tx_m <= tx_pin;
			if ((rx_select_strobe && !src && rx_pin != rx_m) ||
				(tx_select_strobe && !src && tx_pin != tx_m) ||
				(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i))
				calm <= 5'h00;
			else if (calm != 5'h1F)
				calm <= calm + 5'h01;
		end
	end
	chk_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("request not acknowledged");
	chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held");
	chk_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside acknowledge");
	chk_rx_alive: assert property (rx_cnt < 14'h3E80)
		else $error("receive clock stuck");
	chk_tx_alive: assert property (tx_cnt < 14'h3E80)
		else $error("transmit clock stuck");
	chk_rx_high: assert property ($rose(rx_rate_clock_out) |->
		(rx_rate_clock_out || busy) [*8])
		else $error("receive high phase too short");
	chk_tx_low: assert property ($fell(tx_rate_clock_out) |->
		(!tx_rate_clock_out || busy) [*8])
		else $error("transmit low phase too short");
	chk_rx_code: assert property (rd_st && !src |-> wb_dat_o[3:0] == $past(rx_m))
		else $error("latched receive code wrong");
endmodule

bind dual_baud_rate_divider baud_sva baud_sva_inst (
	.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .rx_sel_bit0, .rx_sel_bit1, .rx_sel_bit2, .rx_sel_bit3,
	.rx_select_strobe, .tx_sel_bit0, .tx_sel_bit1, .tx_sel_bit2, .tx_sel_bit3,
	.tx_select_strobe, .rx_rate_clock_out, .tx_rate_clock_out
);

// [verif/dual_baud_rate_divider_test.sv]
`timescale 1ns/100ps

module dual_baud_rate_divider_test import baud_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o, ref_clk, rxo, txo;
	rate_code_t rc = 4'h0;
	rate_code_t tc = 4'h0;
	logic rs = 1'b0;
	logic ts = 1'b0;
	int rxp, txp;
	int n_fail = 0;
	int n_tests = 0;
	divisor_t dv [16] = '{13'h18C0, 13'h1080, 13'h0B40, 13'h0933, 13'h0840, 13'h0420,
		13'h0210, 13'h0108, 13'h00B0, 13'h009E, 13'h0084, 13'h0058, 13'h0042,
		13'h002C, 13'h0021, 13'h0010};

	always #20 clk_sys = ~clk_sys;

	dual_baud_rate_divider dual_baud_rate_divider_inst (
		.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_clock_in(ref_clk),
		.rx_sel_bit0(rc[0]), .rx_sel_bit1(rc[1]), .rx_sel_bit2(rc[2]),
		.rx_sel_bit3(rc[3]), .rx_select_strobe(rs), .tx_sel_bit0(tc[0]),
		.tx_sel_bit1(tc[1]), .tx_sel_bit2(tc[2]), .tx_sel_bit3(tc[3]),
		.tx_select_strobe(ts), .rx_rate_clock_out(rxo), .tx_rate_clock_out(txo)
	);
	line_side line_side_inst (.ref_clk, .rx_clk(rxo), .tx_clk(txo), .rx_per(rxp),
		.tx_per(txp));

	// ********
	// Bench tasks
	// ********
	task chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask

	// ********
	// Scenarios
	// ********
	task t_reset;
		rd(8'h08, 32'hFF, 32'h0, "status");
		rd(8'h0C, 32'hFFFFFFFF, {3'h0, dv[0], 3'h0, dv[0]}, "divisors");
		rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
		wb(1'b1, 8'h08, 32'hFF);
		rd(8'h08, 32'hFF, 32'h0, "status_ro");
		$display("reset test done");
	endtask
	task t_table;
		for (int i = 0; i < 16; i++) begin
			rc <= i[3:0];
			tc <= 4'hF - i[3:0];
			rs <= 1'b1;
			ts <= 1'b1;
			@(posedge clk_sys);
			rs <= 1'b0;
			ts <= 1'b0;
			rd(8'h0C, 32'hFFFFFFFF, {3'h0, dv[15 - i], 3'h0, dv[i]}, "table");
		end
		$display("table test done");
	endtask
	task t_hold;
		rc <= 4'h3;
		tc <= 4'h3;
		repeat (3) @(posedge clk_sys);
		rd(8'h08, 32'hFF, 32'h0F, "status_hold");
		rd(8'h0C, 32'hFFFFFFFF, {3'h0, dv[0], 3'h0, dv[15]}, "div_hold");
		$display("hold test done");
	endtask
	task t_rate;
		rc <= 4'hE;
		tc <= 4'hF;
		rs <= 1'b1;
		ts <= 1'b1;
		repeat (600) @(posedge clk_sys);
		chk("rx_period", rxp, {19'h0, dv[14]});
		chk("tx_period", txp, {19'h0, dv[15]});
		rc <= 4'hD;
		repeat (600) @(posedge clk_sys);
		chk("rx_follow", rxp, {19'h0, dv[13]});
		chk("tx_steady", txp, {19'h0, dv[15]});
		$display("rate test done");
	endtask
	task t_soft;
		wb(1'b1, 8'h04, 32'h4);
		wb(1'b1, 8'h00, 32'h5A);
		wb(1'b1, 8'h04, 32'h7);
		wb(1'b1, 8'h04, 32'h4);
		rd(8'h00, 32'hFFFFFFFF, 32'h5A, "rate_sel");
		rd(8'h04, 32'hFFFFFFFF, 32'h4, "ctrl");
		rd(8'h0C, 32'hFFFFFFFF, {3'h0, dv[5], 3'h0, dv[10]}, "div_soft");
		$display("register test done");
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset;
		t_table;
		t_hold;
		t_rate;
		t_soft;
		wrap_up;
	end
	// The tests need about 1300 cycles; this allows more than seven times that.
	initial begin
		#400000;
		n_fail++;
		wrap_up;
	end
endmodule
